// ===== src/pi_pkg.sv
package pi_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ        = 200000;
  localparam int SAMPLE_MS      = 500;
  localparam int SAMPLE_CYCLES  = SAMPLE_MS * CLK_KHZ;
  localparam int TICK_W         = 27;
  localparam int DIV_STEPS      = 48;

  // ----------------------------------------------------------------
  // arithmetic scaling
  // ----------------------------------------------------------------
  localparam int              FRAC_BITS  = 8;
  localparam logic [9:0]      DRIVE_MAX  = 10'h3E8;
  localparam logic [15:0]     PCT        = 16'h0064;
  localparam logic [12:0]     HOR_MIN    = 13'h0001;
  localparam logic signed [31:0] INTEG_MAX = 32'h0003_E800;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_TARGET  = 4'h0;
  localparam logic [3:0] ADDR_HAND    = 4'h1;
  localparam logic [3:0] ADDR_GAIN    = 4'h2;
  localparam logic [3:0] ADDR_OFFSET  = 4'h3;
  localparam logic [3:0] ADDR_LOW     = 4'h4;
  localparam logic [3:0] ADDR_HIGH    = 4'h5;
  localparam logic [3:0] ADDR_KC      = 4'h6;
  localparam logic [3:0] ADDR_HORIZON = 4'h7;
  localparam logic [3:0] ADDR_CTRL    = 4'h8;
  localparam logic [3:0] ADDR_DRIVE   = 4'h9;
  localparam logic [3:0] ADDR_WORK    = 4'hA;
  localparam logic [3:0] ADDR_STATUS  = 4'hB;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_SENSE_BIT  = 0;
  localparam int CTRL_PRESET_LSB = 1;
  localparam int CTRL_DEC_LSB    = 4;
  localparam int STAT_AUTO_BIT   = 0;
  localparam int STAT_KILL_BIT   = 1;
  localparam int STAT_BUSY_BIT   = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_TARGET  = 16'h0000;
  localparam logic [15:0] RST_HAND    = 16'h0000;
  localparam logic [15:0] RST_GAIN    = 16'h0064;
  localparam logic [15:0] RST_OFFSET  = 16'h0000;
  localparam logic [15:0] RST_LOW     = 16'h0000;
  localparam logic [15:0] RST_HIGH    = 16'h03E8;
  localparam logic [13:0] RST_KC      = 14'h0064;
  localparam logic [12:0] RST_HORIZON = 13'h001E;

  // ----------------------------------------------------------------
  // presets: index 0 means use the programmed values
  // ----------------------------------------------------------------
  localparam logic [13:0] PRESET_KC [0:6] =
    '{14'h0000, 14'h0032, 14'h0064, 14'h012C, 14'h0078, 14'h0064, 14'h0046};
  localparam logic [12:0] PRESET_HOR [0:6] =
    '{13'h0000, 13'h001E, 13'h0078, 13'h0005, 13'h000C, 13'h0001, 13'h0014};
  localparam logic [2:0]  PRESET_LAST = 3'h6;

endpackage

// ===== src/div_if.sv
`timescale 1ns/1ps
`default_nettype none

// request and answer of the integral-step divider
interface div_if;
  logic               start;
  logic signed [47:0] numer;
  logic        [23:0] denom;
  logic               done;
  logic signed [47:0] quot;

  modport master (output start, output numer, output denom, input done, input quot);
  modport slave  (input start, input numer, input denom, output done, output quot);
endinterface

`default_nettype wire

// ===== src/pi_divider.sv
`timescale 1ns/1ps
`default_nettype none

module pi_divider
  import pi_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // request and answer
  div_if.slave     req
);

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [5:0]  cnt;
    logic        neg;
    logic [47:0] rem;
    logic [47:0] quo;
    logic [23:0] den;
  } div_state_t;

  div_state_t div_reg;
  div_state_t div_next;

  // ----------------------------------------------------------------
  // restoring divider, one quotient bit per cycle
  // ----------------------------------------------------------------
  // magnitude division keeps the sign out of the loop; truncates toward zero
  always_comb begin
    logic [47:0] trial;
    trial = '0;
    div_next = div_reg;
    div_next.done = 1'b0;
    if (!nrst) begin
      div_next = '0;
    end else if (req.start && !div_reg.busy) begin
      div_next.busy = 1'b1;
      div_next.cnt  = 6'(DIV_STEPS);
      div_next.neg  = req.numer[47];
      div_next.quo  = req.numer[47] ? 48'(-req.numer) : 48'(req.numer);
      div_next.rem  = '0;
      div_next.den  = req.denom;
    end else if (div_reg.busy) begin
      trial = {div_reg.rem[46:0], div_reg.quo[47]};
      div_next.quo = {div_reg.quo[46:0], 1'b0};
      if (trial >= {24'h00_0000, div_reg.den}) begin
        div_next.rem    = trial - {24'h00_0000, div_reg.den};
        div_next.quo[0] = 1'b1;
      end else begin
        div_next.rem = trial;
      end
      div_next.cnt = div_reg.cnt - 6'h01;
      if (div_reg.cnt == 6'h01) begin
        div_next.busy = 1'b0;
        div_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    div_reg <= div_next;
  end

  // answer stands from done until the next request
  assign req.done = div_reg.done;
  assign req.quot = div_reg.neg ? -$signed(div_reg.quo) : $signed(div_reg.quo);

endmodule

`default_nettype wire

// ===== src/pi_loop_controller.sv
// What this block does
// - auto_select 1 regulates, 0 selects hand
// - kill forces zero, ignores auto_select meanwhile
// - kill at 1 resets output at once
// - hand mode drives hand_value
// - entering auto preloads integral with hand_value
// - raw above high limit uses high limit
// - raw below low limit uses low limit
// - working equals target leaves output unchanged
// - positive sense: above target lowers output
// - negative sense: above target raises output
// - output recomputed once every 500 ms
// - output limited to 0 through 1000
// - temperature and pressure presets, positive sense
// - two level presets, positive sense
// - shown_decimals never touches the arithmetic
// - error is target minus working value
// - output is P plus I step plus sum
`timescale 1ns/1ps
`default_nettype none

module pi_loop_controller
  import pi_pkg::*;
#(
  parameter int SAMPLE_PERIOD = pi_pkg::SAMPLE_CYCLES
)
(
  // clock and reset
  input  wire logic               clock,
  input  wire logic               nrst,
  // register port
  input  wire logic [3:0]         addr,
  input  wire logic [15:0]        wr_data,
  input  wire logic               wr_en,
  input  wire logic               rd_en,
  output var  logic [15:0]        rd_data,
  // process side
  input  wire logic signed [15:0] measured_value,
  input  wire logic               auto_select,
  input  wire logic               output_kill,
  output var  logic [9:0]         drive_output
);

  import pi_pkg::*;

  typedef enum logic [1:0] {
    ST_WAIT = 2'b01,
    ST_DIV  = 2'b10
  } step_t;

  typedef struct packed {
    logic [15:0]        target;
    logic [15:0]        hand;
    logic [15:0]        gain;
    logic [15:0]        offset;
    logic [15:0]        low;
    logic [15:0]        high;
    logic [13:0]        kc;
    logic [12:0]        horizon;
    logic               sense;
    logic [2:0]         preset;
    logic [1:0]         decimals;
    logic [15:0]        mv1;
    logic [15:0]        mv2;
    logic [15:0]        mv3;
    logic [15:0]        mv_ok;
    logic [2:0]         auto_s;
    logic [2:0]         kill_s;
    logic               auto_ok;
    logic               kill_ok;
    logic [TICK_W-1:0]  tick;
    step_t              step;
    logic               running;
    logic               start;
    logic signed [47:0] numer;
    logic [23:0]        denom;
    logic signed [31:0] integ;
    logic signed [47:0] p_term;
    logic [9:0]         drive;
    logic [15:0]        rd;
  } ctl_state_t;

  ctl_state_t ctl_reg;
  ctl_state_t ctl_next;
  div_if      div_bus ();

  // ----------------------------------------------------------------
  // integral-step divider
  // ----------------------------------------------------------------
  pi_divider u_div (
    .clock (clock),
    .nrst  (nrst),
    .req   (div_bus.slave)
  );

  assign div_bus.start = ctl_reg.start;
  assign div_bus.numer = ctl_reg.numer;
  assign div_bus.denom = ctl_reg.denom;

  // ----------------------------------------------------------------
  // working value, error and terms
  // ----------------------------------------------------------------
  logic signed [19:0] work;
  logic signed [20:0] err;
  logic signed [35:0] prod;
  logic        [13:0] kc_eff;
  logic        [12:0] hor_eff;
  logic               sense_eff;

  // presets replace kc and horizon and force positive sense
  always_comb begin
    if (ctl_reg.preset != 3'h0 && ctl_reg.preset <= PRESET_LAST) begin
      kc_eff    = PRESET_KC[ctl_reg.preset];
      hor_eff   = PRESET_HOR[ctl_reg.preset];
      sense_eff = 1'b0;
    end else begin
      kc_eff    = ctl_reg.kc;
      hor_eff   = ctl_reg.horizon;
      sense_eff = ctl_reg.sense;
    end
  end

  // limits compare against the raw input, the scaled value is used otherwise
  always_comb begin
    logic signed [31:0] scaled;
    scaled = 32'($signed(ctl_reg.mv_ok)) * 32'($signed(ctl_reg.gain));
    scaled = scaled / 32'($signed({16'h0000, PCT})) + 32'($signed(ctl_reg.offset));
    if ($signed(ctl_reg.mv_ok) > $signed(ctl_reg.high)) begin
      work = 20'($signed(ctl_reg.high));
    end else if ($signed(ctl_reg.mv_ok) < $signed(ctl_reg.low)) begin
      work = 20'($signed(ctl_reg.low));
    end else begin
      work = 20'(scaled);
    end
  end

  // decimals setting is deliberately absent from this path
  always_comb begin
    err = 21'($signed(ctl_reg.target)) - 21'(work);
    if (sense_eff) begin
      err = -err;
    end
    prod = 36'($signed({1'b0, kc_eff})) * 36'(err);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic signed [48:0] isum;
    logic signed [47:0] total;
    logic [23:0]        den;
    isum  = '0;
    total = '0;
    den   = '0;
    ctl_next = ctl_reg;
    ctl_next.start = 1'b0;
    ctl_next.rd    = 16'h0000;
    if (!nrst) begin
      ctl_next = '0;
      ctl_next.target  = RST_TARGET;
      ctl_next.hand    = RST_HAND;
      ctl_next.gain    = RST_GAIN;
      ctl_next.offset  = RST_OFFSET;
      ctl_next.low     = RST_LOW;
      ctl_next.high    = RST_HIGH;
      ctl_next.kc      = RST_KC;
      ctl_next.horizon = RST_HORIZON;
      ctl_next.step    = ST_WAIT;
    end else begin
      // pins pass three flops; a value counts once stages two and three agree
      ctl_next.mv1 = measured_value;
      ctl_next.mv2 = ctl_reg.mv1;
      ctl_next.mv3 = ctl_reg.mv2;
      if (ctl_reg.mv2 == ctl_reg.mv3) begin
        ctl_next.mv_ok = ctl_reg.mv3;
      end
      ctl_next.auto_s = {ctl_reg.auto_s[1:0], auto_select};
      ctl_next.kill_s = {ctl_reg.kill_s[1:0], output_kill};
      if (ctl_reg.auto_s[1] == ctl_reg.auto_s[2]) begin
        ctl_next.auto_ok = ctl_reg.auto_s[2];
      end
      if (ctl_reg.kill_s[1] == ctl_reg.kill_s[2]) begin
        ctl_next.kill_ok = ctl_reg.kill_s[2];
      end

      // register writes
      if (wr_en) begin
        unique case (addr)
          ADDR_TARGET:  ctl_next.target  = wr_data;
          ADDR_HAND:    ctl_next.hand    = wr_data;
          ADDR_GAIN:    ctl_next.gain    = wr_data;
          ADDR_OFFSET:  ctl_next.offset  = wr_data;
          ADDR_LOW:     ctl_next.low     = wr_data;
          ADDR_HIGH:    ctl_next.high    = wr_data;
          ADDR_KC:      ctl_next.kc      = wr_data[13:0];
          ADDR_HORIZON: ctl_next.horizon = wr_data[12:0];
          ADDR_CTRL: begin
            ctl_next.sense    = wr_data[CTRL_SENSE_BIT];
            ctl_next.preset   = wr_data[CTRL_PRESET_LSB +: 3];
            ctl_next.decimals = wr_data[CTRL_DEC_LSB +: 2];
          end
          default: ;
        endcase
      end

      // register reads, data stand only in the following cycle
      if (rd_en) begin
        unique case (addr)
          ADDR_TARGET:  ctl_next.rd = ctl_reg.target;
          ADDR_HAND:    ctl_next.rd = ctl_reg.hand;
          ADDR_GAIN:    ctl_next.rd = ctl_reg.gain;
          ADDR_OFFSET:  ctl_next.rd = ctl_reg.offset;
          ADDR_LOW:     ctl_next.rd = ctl_reg.low;
          ADDR_HIGH:    ctl_next.rd = ctl_reg.high;
          ADDR_KC:      ctl_next.rd = {2'h0, ctl_reg.kc};
          ADDR_HORIZON: ctl_next.rd = {3'h0, ctl_reg.horizon};
          ADDR_CTRL:    ctl_next.rd = {10'h000, ctl_reg.decimals, ctl_reg.preset, ctl_reg.sense};
          ADDR_DRIVE:   ctl_next.rd = {6'h00, ctl_reg.drive};
          ADDR_WORK:    ctl_next.rd = work[15:0];
          ADDR_STATUS: begin
            ctl_next.rd[STAT_AUTO_BIT] = ctl_reg.running;
            ctl_next.rd[STAT_KILL_BIT] = ctl_reg.kill_ok;
            ctl_next.rd[STAT_BUSY_BIT] = (ctl_reg.step == ST_DIV);
          end
          default:      ctl_next.rd = 16'h0000;
        endcase
      end

      // free-running sample tick
      if (ctl_reg.tick >= TICK_W'(SAMPLE_PERIOD - 1)) begin
        ctl_next.tick = '0;
      end else begin
        ctl_next.tick = ctl_reg.tick + 1'b1;
      end

      // override outranks the mode selector
      if (ctl_reg.kill_ok) begin
        ctl_next.drive   = 10'h000;
        ctl_next.running = 1'b0;
        ctl_next.step    = ST_WAIT;
      end else if (!ctl_reg.auto_ok) begin
        // hand values above range are clipped rather than wrapped
        ctl_next.drive   = (ctl_reg.hand > {6'h00, DRIVE_MAX}) ? DRIVE_MAX
                                                              : ctl_reg.hand[9:0];
        ctl_next.running = 1'b0;
        ctl_next.step    = ST_WAIT;
      end else if (!ctl_reg.running) begin
        // entering auto: the hand value becomes the starting integral sum
        ctl_next.running = 1'b1;
        ctl_next.integ   = 32'($signed({1'b0, ctl_reg.hand})) <<< FRAC_BITS;
        if (ctl_next.integ > INTEG_MAX) begin
          ctl_next.integ = INTEG_MAX;
        end
        ctl_next.step = ST_WAIT;
      end else begin
        unique case (ctl_reg.step)
          ST_WAIT: begin
            if (ctl_reg.tick == '0 && err != '0) begin
              // integral step is kc*e*Ts/Ti scaled by 2^8; Ts is half a second
              den = 24'(({11'h000, (hor_eff < HOR_MIN) ? HOR_MIN : hor_eff}) * 24'(PCT));
              ctl_next.denom  = den;
              ctl_next.numer  = 48'(prod) <<< (FRAC_BITS - 1);
              ctl_next.p_term = 48'(prod) / 48'($signed({32'h0, PCT}));
              ctl_next.start  = 1'b1;
              ctl_next.step   = ST_DIV;
            end
          end
          ST_DIV: begin
            if (div_bus.done) begin
              isum = 49'(ctl_reg.integ) + 49'(div_bus.quot);
              if (isum < 49'sd0) begin
                ctl_next.integ = '0;
              end else if (isum > 49'(INTEG_MAX)) begin
                ctl_next.integ = INTEG_MAX;
              end else begin
                ctl_next.integ = 32'(isum);
              end
              total = ctl_reg.p_term + 48'(ctl_next.integ >>> FRAC_BITS);
              if (total < 48'sd0) begin
                ctl_next.drive = 10'h000;
              end else if (total > 48'($signed({38'h0, DRIVE_MAX}))) begin
                ctl_next.drive = DRIVE_MAX;
              end else begin
                ctl_next.drive = total[9:0];
              end
              ctl_next.step = ST_WAIT;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    ctl_reg <= ctl_next;
  end

  // outputs straight from flops
  assign rd_data      = ctl_reg.rd;
  assign drive_output = ctl_reg.drive;

endmodule

`default_nettype wire

// ===== testbench/process_plant.sv
`timescale 1ns/1ps
`default_nettype none

module process_plant (
  // clock
  input  wire logic               clock,
  // process level and actuator
  input  wire logic signed [15:0] level_in,
  input  wire logic [9:0]         drive_output,
  output var  logic signed [15:0] measured_value,
  output var  logic [9:0]         actuator_level
);
  // transducer reports one cycle late; actuator just follows the drive
  always_ff @(posedge clock) begin
    measured_value <= level_in;
    actuator_level <= drive_output;
  end
endmodule

`default_nettype wire

// ===== testbench/pi_loop_chk.sv
`timescale 1ns/1ps
`default_nettype none

module pi_loop_chk
  import pi_pkg::*;
#(
  parameter int SAMPLE_PERIOD = 200
)
(
  // clock and reset
  input wire logic               clock,
  input wire logic               nrst,
  // register port
  input wire logic [3:0]         addr,
  input wire logic [15:0]        wr_data,
  input wire logic               wr_en,
  input wire logic               rd_en,
  input wire logic [15:0]        rd_data,
  // process side
  input wire logic signed [15:0] measured_value,
  input wire logic               auto_select,
  input wire logic               output_kill,
  input wire logic [9:0]         drive_output
);
  // ------------------------------------------------------------
  // helper state
  // ------------------------------------------------------------
  logic [15:0] hand_reg;
  logic [7:0]  hand_age_reg;
  logic [31:0] auto_age_reg;
  logic [31:0] gap_reg;
  logic [9:0]  last_drive_reg;
  wire  logic  hand_wr = wr_en && addr == ADDR_HAND;
  wire  logic [9:0] hand_clip = (hand_reg > 16'h03E8) ? DRIVE_MAX : hand_reg[9:0];

  // ages count from the raw pins, so they include the synchroniser delay
  always_ff @(posedge clock) begin
    last_drive_reg <= drive_output;
    if (!nrst) begin
      hand_reg     <= 16'h0000;
      hand_age_reg <= 8'h00;
      auto_age_reg <= 32'h0000_0000;
      gap_reg      <= 32'h0000_0000;
    end else begin
      if (hand_wr) hand_reg <= wr_data;
      if (hand_wr || auto_select || output_kill) hand_age_reg <= 8'h00;
      else if (hand_age_reg != 8'hFF) hand_age_reg <= hand_age_reg + 8'h01;
      auto_age_reg <= (auto_select && !output_kill) ? auto_age_reg + 32'h1 : 32'h0;
      gap_reg <= (drive_output != last_drive_reg) ? 32'h0 : gap_reg + 32'h1;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  reset_clear_a: assert property (disable iff (1'b0)
    !nrst |=> drive_output == 10'h000 && rd_data == 16'h0000)
    else $error("outputs not cleared by reset");
  drive_range_a: assert property (
    drive_output <= DRIVE_MAX)
    else $error("drive above full scale");
  kill_zero_a: assert property (
    output_kill [*8] |-> drive_output == 10'h000)
    else $error("override did not clear drive");
  kill_hold_a: assert property (
    output_kill [*8] ##1 output_kill |-> $stable(drive_output))
    else $error("drive moved under override");
  hand_track_a: assert property (
    hand_age_reg >= 8'd10 |-> drive_output == hand_clip)
    else $error("hand mode drive differs from hand value");
  sample_gap_a: assert property (
    drive_output != last_drive_reg && auto_age_reg > gap_reg + 32'd12
      |-> gap_reg >= SAMPLE_PERIOD - 1)
    else $error("auto updates closer than one sample");
  rd_drive_a: assert property (
    $past(rd_en) && $past(addr) == ADDR_DRIVE |-> rd_data == {6'h00, $past(drive_output)})
    else $error("drive readback wrong");
  rd_idle_a: assert property (
    !$past(rd_en) |-> rd_data == 16'h0000)
    else $error("read data not idle");

  hand_seen_c: cover property (hand_age_reg == 8'd10 && hand_clip != 10'h000);
  kill_seen_c: cover property (output_kill [*8] ##1 $changed(auto_select));
  auto_step_c: cover property (drive_output != last_drive_reg && auto_age_reg > 32'd20);
endmodule

`default_nettype wire

// ===== testbench/pi_loop_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none

module pi_loop_controller_tb;
  import pi_pkg::*;

  // ------------------------------------------------------------
  // signals and tables
  // ------------------------------------------------------------
  localparam int SAMPLE = 200; // short sample period keeps the run brief
  logic               clock;
  logic               nrst;
  logic [3:0]         addr;
  logic [15:0]        wr_data;
  logic               wr_en;
  logic               rd_en;
  logic [15:0]        rd_data;
  logic signed [15:0] level;
  logic signed [15:0] measured_value;
  logic               auto_select;
  logic               output_kill;
  logic [9:0]         drive_output;
  int                 mismatches;
  int                 checked;
  int                 cycles;
  int                 n;
  logic [15:0]        v;
  logic [3:0]  rst_addr [8] = '{4'h0, 4'h2, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hC};
  logic [15:0] rst_exp  [8] = '{16'h0000, 16'h0064, 16'h03E8, 16'h0064, 16'h001E,
                                16'h0000, 16'h0000, 16'h0000};
  // rows: raw, gain, offset, working value (second is above high, third below low)
  logic [15:0] row_raw  [4] = '{16'h0064, 16'h04B0, 16'hFFCE, 16'h0190};
  logic [15:0] row_gain [4] = '{16'h00C8, 16'h0064, 16'h0064, 16'h0064};
  logic [15:0] row_off  [4] = '{16'h0005, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] row_work [4] = '{16'h00CD, 16'h03E8, 16'h0000, 16'h0190};
  int pre_kc  [7] = '{0, 50, 100, 300, 120, 100, 70};
  int pre_hor [7] = '{0, 30, 120, 5, 12, 1, 20};

  pi_loop_controller #(.SAMPLE_PERIOD(SAMPLE)) i_dut (
    .clock          (clock),
    .nrst           (nrst),
    .addr           (addr),
    .wr_data        (wr_data),
    .wr_en          (wr_en),
    .rd_en          (rd_en),
    .rd_data        (rd_data),
    .measured_value (measured_value),
    .auto_select    (auto_select),
    .output_kill    (output_kill),
    .drive_output   (drive_output)
  );

  process_plant i_plant (
    .clock          (clock),
    .level_in       (level),
    .drive_output   (drive_output),
    .measured_value (measured_value),
    .actuator_level ()
  );

  always #2.5 clock = ~clock;

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // a hang counts as a failure and still reaches the verdict
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // settle one step past the edge so registered outputs have landed
  task automatic idle(int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic wait_change(output int cnt);
    logic [9:0] old;
    old = drive_output;
    cnt = 0;
    while (drive_output === old && cnt < 3 * SAMPLE) begin
      idle(1);
      cnt++;
    end
  endtask

  // one sample from a fresh preload of hand, integral in 1/256 units
  function automatic int expect_drive(int kc, int hor, int hand, int e);
    int p;
    int integ;
    p = kc * e / 100;
    integ = hand * 256 + kc * e * 128 / (100 * hor);
    integ = integ < 0 ? 0 : (integ > 256000 ? 256000 : integ);
    integ = p + (integ >>> 8);
    return integ < 0 ? 0 : (integ > 1000 ? 1000 : integ);
  endfunction

  // mode direction may change only while the loop is in hand mode
  task automatic run_auto(logic [15:0] ctrl, int exp);
    @(posedge clock);
    auto_select <= 1'b0;
    // let the synchroniser leave auto before the direction changes
    idle(8);
    wr(ADDR_CTRL, ctrl);
    idle(12);
    check("hand", {6'h00, drive_output}, 16'h01F4);
    @(posedge clock);
    auto_select <= 1'b1;
    wait_change(n);
    check("auto step", {6'h00, drive_output}, 16'(exp));
    $display("test auto ctrl %h done", ctrl);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    addr = 4'h0;
    wr_data = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    level = 16'sh0000;
    auto_select = 1'b0;
    output_kill = 1'b0;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    wr(ADDR_DRIVE, 16'h0155); // read-only place keeps its value
    for (int i = 0; i < 8; i++) begin
      rd(rst_addr[i], v);
      check("reset value", v, rst_exp[i]);
    end
    $display("test reset done");
    wr(ADDR_LOW, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_GAIN, row_gain[i]);
      wr(ADDR_OFFSET, row_off[i]);
      @(posedge clock);
      level <= row_raw[i];
      idle(SAMPLE + 20);
      rd(ADDR_WORK, v);
      check("working value", v, row_work[i]);
    end
    $display("test scaling done");
    wr(ADDR_HAND, 16'h03E8);
    idle(12);
    check("hand full", {6'h00, drive_output}, 16'h03E8);
    wr(ADDR_HAND, 16'h01F4);
    @(posedge clock);
    output_kill <= 1'b1;
    idle(10);
    check("override", {6'h00, drive_output}, 16'h0000);
    @(posedge clock);
    auto_select <= 1'b1;
    idle(10);
    check("override auto", {6'h00, drive_output}, 16'h0000);
    rd(ADDR_STATUS, v);
    check("status", v, 16'(1 << STAT_KILL_BIT));
    @(posedge clock);
    output_kill <= 1'b0;
    auto_select <= 1'b0;
    $display("test override done");
    wr(ADDR_TARGET, 16'h0258);
    run_auto(16'h0000, expect_drive(100, 30, 500, 200));
    wait_change(n);
    check("sample gap", 16'(n), 16'(SAMPLE));
    check("second step", {6'h00, drive_output}, 16'h02C2);
    run_auto(16'h0001, expect_drive(100, 30, 500, -200));
    for (int p = 1; p < 7; p++) begin
      run_auto(16'h0031 | 16'(p << 1), expect_drive(pre_kc[p], pre_hor[p], 500, 200));
    end
    // zero error while running: a recompute would drop the P part
    wr(ADDR_TARGET, 16'h0190);
    idle(2 * SAMPLE + 60);
    check("balanced", {6'h00, drive_output}, 16'(expect_drive(70, 20, 500, 200)));
    $display("test balanced done");
    wr(ADDR_TARGET, 16'h4E20);
    wr(ADDR_KC, 16'h270F);
    run_auto(16'h0000, 1000);
    wr(ADDR_TARGET, 16'h018F);
    wait_change(n);
    check("no windup", {6'h00, drive_output}, 16'h0383);
    $display("test saturation done");
    finish_test();
  end
endmodule

bind pi_loop_controller pi_loop_chk #(.SAMPLE_PERIOD(SAMPLE_PERIOD)) i_chk (
  .clock          (clock),
  .nrst           (nrst),
  .addr           (addr),
  .wr_data        (wr_data),
  .wr_en          (wr_en),
  .rd_en          (rd_en),
  .rd_data        (rd_data),
  .measured_value (measured_value),
  .auto_select    (auto_select),
  .output_kill    (output_kill),
  .drive_output   (drive_output)
);

`default_nettype wire
